/* shared/cpupd_pkg.sv */
// ============================================================
// Shared constants and types for the counter parameter update block.
package cpupd_pkg;

    // Counter width and clock rate.
    localparam int CNT_W  = 32;
    localparam int CLK_HZ = 20_000_000;

    // Measurement intervals in milliseconds and their cycle counts.
    localparam int PER_SHORT_MS  = 10;
    localparam int PER_MID_MS    = 100;
    localparam int PER_LONG_MS   = 1000;
    localparam int PER_SHORT_CYC = CLK_HZ / 1000 * PER_SHORT_MS;
    localparam int PER_MID_CYC   = CLK_HZ / 1000 * PER_MID_MS;
    localparam int PER_LONG_CYC  = CLK_HZ / 1000 * PER_LONG_MS;

    // Interval codes carried on the new interval input, in milliseconds.
    localparam logic [15:0] PER_SHORT_VAL = 16'h000a;
    localparam logic [15:0] PER_MID_VAL   = 16'h0064;
    localparam logic [15:0] PER_LONG_VAL  = 16'h03e8;

    // Scale from edges per interval to hertz.
    localparam logic [9:0] MULT_SHORT = 10'h064;
    localparam logic [9:0] MULT_MID   = 10'h00a;
    localparam logic [9:0] MULT_LONG  = 10'h001;

    // Heading encodings: forward and backward.
    localparam logic [15:0] DIR_UP   = 16'h0001;
    localparam logic [15:0] DIR_DOWN = 16'hffff;

    // Status codes.
    localparam logic [15:0] ST_OK        = 16'h0000;
    localparam logic [15:0] ST_BAD_ID    = 16'h80a1;
    localparam logic [15:0] ST_BAD_DIR   = 16'h80b1;
    localparam logic [15:0] ST_BAD_COUNT = 16'h80b2;
    localparam logic [15:0] ST_BAD_REF   = 16'h80b3;
    localparam logic [15:0] ST_BAD_PER   = 16'h80b4;
    localparam logic [15:0] ST_MULTI     = 16'h80c0;
    localparam logic [15:0] ST_DISABLED  = 16'h80d0;

    // Reset values.
    localparam logic [15:0] RST_STATUS = 16'h0000;

    typedef enum logic [1:0] {PSEL_SHORT, PSEL_MID, PSEL_LONG} cpupd_period_t;

    localparam cpupd_period_t RST_PERIOD = PSEL_LONG;

    // One control operation: request bits and their new values.
    typedef struct packed {
        logic        dir_req;
        logic        count_load_request;
        logic        reference_load_request;
        logic        period_req;
        logic [15:0] new_dir;
        logic [31:0] new_count_value;
        logic [31:0] new_reference_value;
        logic [15:0] new_period;
    } cpupd_op_t;

    // True when an interval value is one of the three settings.
    function automatic logic period_legal(input logic [15:0] v);
        period_legal = (v == PER_SHORT_VAL) || (v == PER_MID_VAL) || (v == PER_LONG_VAL);
    endfunction : period_legal

    // Maps a legal interval value to its code.
    function automatic cpupd_period_t period_code(input logic [15:0] v);
        if (v == PER_SHORT_VAL) begin
            period_code = PSEL_SHORT;
        end else if (v == PER_MID_VAL) begin
            period_code = PSEL_MID;
        end else begin
            period_code = PSEL_LONG;
        end
    endfunction : period_code

endpackage : cpupd_pkg

/* rtl/cpupd_check.sv */
`timescale 1ns/1ps
// ============================================================
// Operation check: picks the status code of one control operation.
module cpupd_check #(
    parameter int         CNT_W      = cpupd_pkg::CNT_W,
    parameter logic [7:0] COUNTER_ID = 8'h01
) (
    input  wire cpupd_pkg::cpupd_op_t op,
    input  wire logic [7:0]           handle,
    input  wire logic                 enable,
    input  wire logic                 access_busy,
    output logic [15:0]               status
);

    // True when a 32-bit value fits the signed counter width.
    function automatic logic fits(input logic [31:0] v);
        fits = (v[31:CNT_W-1] == {(33 - CNT_W){v[31]}});
    endfunction : fits

    // Errors in fixed priority; the first one found is reported.
    always_comb begin
        status = cpupd_pkg::ST_OK;
        if (handle != COUNTER_ID) begin
            status = cpupd_pkg::ST_BAD_ID;
        end else if (!enable) begin
            status = cpupd_pkg::ST_DISABLED;
        end else if (access_busy) begin
            status = cpupd_pkg::ST_MULTI;
        end else if (op.dir_req && op.new_dir != cpupd_pkg::DIR_UP && op.new_dir != cpupd_pkg::DIR_DOWN) begin
            status = cpupd_pkg::ST_BAD_DIR;
        end else if (op.count_load_request && !fits(op.new_count_value)) begin
            status = cpupd_pkg::ST_BAD_COUNT;
        end else if (op.reference_load_request && !fits(op.new_reference_value)) begin
            status = cpupd_pkg::ST_BAD_REF;
        end else if (op.period_req && !cpupd_pkg::period_legal(op.new_period)) begin
            status = cpupd_pkg::ST_BAD_PER;
        end
    end

endmodule : cpupd_check

/* rtl/cpupd_count_core.sv */
`timescale 1ns/1ps
// ============================================================
// Count register and frequency measurement.
module cpupd_count_core #(
    parameter int CNT_W     = cpupd_pkg::CNT_W,
    parameter int SHORT_CYC = cpupd_pkg::PER_SHORT_CYC,
    parameter int MID_CYC   = cpupd_pkg::PER_MID_CYC,
    parameter int LONG_CYC  = cpupd_pkg::PER_LONG_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     step,
    input  wire logic                     up,
    input  wire logic                     clear,
    input  wire logic                     load,
    input  wire logic [CNT_W-1:0]         load_val,
    input  wire logic                     restart,
    input  wire cpupd_pkg::cpupd_period_t period,
    output logic [CNT_W-1:0]              count,
    output logic [CNT_W-1:0]              freq
);

    logic [CNT_W-1:0] edges;
    logic [31:0]      tick;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] next_edges;
    logic [CNT_W-1:0] next_freq;
    logic [31:0]      next_tick;
    logic [CNT_W-1:0] base;
    logic [31:0]      limit;
    logic [9:0]       mult;

    // A load replaces the base and an edge of the same cycle still counts.
    always_comb begin
        base = load ? load_val : count;
        next_count = base;
        if (clear) begin
            next_count = '0;
        end else if (step) begin
            next_count = up ? base + 1'b1 : base - 1'b1;
        end
    end

    // Interval timer; at each end the edge total becomes the frequency in hertz.
    always_comb begin
        case (period)
            cpupd_pkg::PSEL_SHORT: begin
                limit = 32'(SHORT_CYC - 1);
                mult  = cpupd_pkg::MULT_SHORT;
            end
            cpupd_pkg::PSEL_MID: begin
                limit = 32'(MID_CYC - 1);
                mult  = cpupd_pkg::MULT_MID;
            end
            default: begin
                limit = 32'(LONG_CYC - 1);
                mult  = cpupd_pkg::MULT_LONG;
            end
        endcase
        next_freq  = freq;
        next_tick  = tick + 32'h1;
        next_edges = edges + {{(CNT_W - 1){1'b0}}, step};
        if (restart || tick >= limit) begin
            next_tick  = 32'h0;
            next_edges = {{(CNT_W - 1){1'b0}}, step};
            if (!restart) begin
                next_freq = CNT_W'(edges * mult);
            end
        end
    end

    // Registers of the count core.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
            edges <= '0;
            freq  <= '0;
            tick  <= 32'h0;
        end else begin
            count <= next_count;
            edges <= next_edges;
            freq  <= next_freq;
            tick  <= next_tick;
        end
    end

endmodule : cpupd_count_core

/* rtl/cpupd_top.sv */
`timescale 1ns/1ps
// ============================================================
module cpupd_top #(
    parameter int         CNT_W      = cpupd_pkg::CNT_W,
    parameter logic [7:0] COUNTER_ID = 8'h01, // Arbitrary value.
    parameter int         SHORT_CYC  = cpupd_pkg::PER_SHORT_CYC,
    parameter int         MID_CYC    = cpupd_pkg::PER_MID_CYC,
    parameter int         LONG_CYC   = cpupd_pkg::PER_LONG_CYC
) (
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic                 OP_REQ,
    input  wire cpupd_pkg::cpupd_op_t OP,
    input  wire logic [7:0]           COUNTER_HANDLE,
    input  wire logic                 CFG_ENABLE,
    input  wire logic                 CFG_INTERNAL_DIR,
    input  wire logic                 CFG_FREQ_MODE,
    input  wire logic                 CFG_RESET_USE,
    input  wire logic                 ACCESS_BUSY,
    input  wire logic                 PIN_COUNT,
    input  wire logic                 PIN_DIR,
    input  wire logic                 PIN_RESET,
    output logic                      OP_DONE,
    output logic                      ENABLE_OUT_FLAG,
    output logic                      BUSY,
    output logic [15:0]               STATUS,
    output logic [CNT_W-1:0]          COUNT_VALUE,
    output logic                      EQ_EVENT,
    output logic                      RST_EVENT,
    output logic                      DIR_EVENT,
    output logic                      DIR_UP_NOW
);

    // ============================================================
    // Pin synchronisers and edge detection.
    logic [2:0] pin_raw;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;

    assign pin_raw = {PIN_RESET, PIN_DIR, PIN_COUNT};

    // Three flops per pin; logic reads the second and the third, never the first.
    // The chain keeps sampling during reset, so it holds the true pin levels when
    // reset ends; a pin idling high would otherwise look like a fresh edge.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                pin_meta[gi] <= pin_raw[gi];
                pin_sync[gi] <= pin_meta[gi];
                pin_prev[gi] <= pin_sync[gi];
            end
        end
    endgenerate

    // ============================================================
    // Operation decode and parameter state.
    logic [15:0]              op_status;
    logic                     op_ok;
    logic                     clear;
    logic                     step;
    logic                     eff_up;
    logic                     dir_up;
    logic [CNT_W-1:0]         ref_value;
    cpupd_pkg::cpupd_period_t period;
    logic                     next_dir_up;
    logic [CNT_W-1:0]         next_ref_value;
    cpupd_pkg::cpupd_period_t next_period;
    logic                     count_load;
    logic                     per_load;
    logic [CNT_W-1:0]         core_count;
    logic [CNT_W-1:0]         core_freq;

    cpupd_check #(
        .CNT_W      (CNT_W),
        .COUNTER_ID (COUNTER_ID)
    ) u_check (
        .op          (OP),
        .handle      (COUNTER_HANDLE),
        .enable      (CFG_ENABLE),
        .access_busy (ACCESS_BUSY),
        .status      (op_status)
    );

    // Updates apply only when the whole operation is free of errors.
    assign op_ok      = OP_REQ && (op_status == cpupd_pkg::ST_OK);
    assign count_load = op_ok && OP.count_load_request;
    assign per_load   = op_ok && OP.period_req;
    assign eff_up     = CFG_INTERNAL_DIR ? dir_up : pin_sync[1];
    assign clear      = CFG_RESET_USE && !CFG_FREQ_MODE && pin_sync[2];
    assign step       = pin_sync[0] && !pin_prev[0];

    // Next heading, reference and interval; values without request are ignored.
    always_comb begin
        next_dir_up    = dir_up;
        next_ref_value = ref_value;
        next_period    = period;
        if (op_ok && OP.dir_req && CFG_INTERNAL_DIR) begin
            next_dir_up = (OP.new_dir == cpupd_pkg::DIR_UP);
        end
        if (op_ok && OP.reference_load_request) begin
            next_ref_value = OP.new_reference_value[CNT_W-1:0];
        end
        if (per_load) begin
            next_period = cpupd_pkg::period_code(OP.new_period);
        end
    end

    // Parameter registers.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dir_up    <= 1'b1;
            ref_value <= '0;
            period    <= cpupd_pkg::RST_PERIOD;
        end else begin
            dir_up    <= next_dir_up;
            ref_value <= next_ref_value;
            period    <= next_period;
        end
    end

    // ============================================================
    // Count core.
    cpupd_count_core #(
        .CNT_W     (CNT_W),
        .SHORT_CYC (SHORT_CYC),
        .MID_CYC   (MID_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_core (
        .clk      (CLK),
        .rst_n    (RST_N),
        .step     (step),
        .up       (eff_up),
        .clear    (clear),
        .load     (count_load),
        .load_val (OP.new_count_value[CNT_W-1:0]),
        .restart  (per_load),
        .period   (period),
        .count    (core_count),
        .freq     (core_freq)
    );

    // ============================================================
    // Outputs: operation answer, count view and events.
    logic             eq_prev;
    logic             eff_prev;
    logic             next_op_done;
    logic             next_enable_out_flag;
    logic [15:0]      next_status;
    logic [CNT_W-1:0] next_count_value;
    logic             next_eq_event;
    logic             next_rst_event;
    logic             next_dir_event;

    // Answer of an operation; the count itself is never part of it.
    always_comb begin
        next_op_done         = OP_REQ;
        next_enable_out_flag = ENABLE_OUT_FLAG;
        next_status          = STATUS;
        if (OP_REQ) begin
            next_enable_out_flag = op_ok;
            next_status          = op_status;
        end
    end

    // Count view and the three events.
    always_comb begin
        next_count_value = CFG_FREQ_MODE ? core_freq : core_count;
        next_eq_event    = (core_count == ref_value) && !eq_prev && !CFG_FREQ_MODE;
        next_rst_event   = CFG_RESET_USE && pin_sync[2] && !pin_prev[2];
        next_dir_event   = (eff_up != eff_prev);
    end

    // Output registers; busy is held at zero.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            OP_DONE         <= 1'b0;
            ENABLE_OUT_FLAG <= 1'b0;
            BUSY            <= 1'b0;
            STATUS          <= cpupd_pkg::RST_STATUS;
            COUNT_VALUE     <= '0;
            EQ_EVENT        <= 1'b0;
            RST_EVENT       <= 1'b0;
            DIR_EVENT       <= 1'b0;
            DIR_UP_NOW      <= 1'b1;
            eq_prev         <= 1'b1;
        end else begin
            OP_DONE         <= next_op_done;
            ENABLE_OUT_FLAG <= next_enable_out_flag;
            BUSY            <= 1'b0;
            STATUS          <= next_status;
            COUNT_VALUE     <= next_count_value;
            EQ_EVENT        <= next_eq_event;
            RST_EVENT       <= next_rst_event;
            DIR_EVENT       <= next_dir_event;
            DIR_UP_NOW      <= eff_up;
            eq_prev         <= (core_count == ref_value);
        end
    end

    // Previous effective direction; it follows the direction through reset too,
    // so a pin-held backward heading gives no direction event when reset ends.
    always_ff @(posedge CLK) begin
        eff_prev <= eff_up;
    end

    // ============================================================
    // Assertions.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    dir_load_a: assert property (
        op_ok && OP.dir_req && CFG_INTERNAL_DIR |=> dir_up == ($past(OP.new_dir) == cpupd_pkg::DIR_UP))
        else $error("Heading not loaded.");

    dir_ignored_a: assert property (
        OP_REQ && !CFG_INTERNAL_DIR |=> dir_up == $past(dir_up))
        else $error("Heading changed under external direction.");

    count_load_a: assert property (
        count_load && !clear && !step |=> core_count == $past(OP.new_count_value[CNT_W-1:0]))
        else $error("Count not loaded.");

    count_keep_a: assert property (
        OP_REQ && !OP.count_load_request && !step && !clear |=> core_count == $past(core_count))
        else $error("Count changed without request.");

    ref_load_a: assert property (
        op_ok && OP.reference_load_request |=> ref_value == $past(OP.new_reference_value[CNT_W-1:0]))
        else $error("Reference not loaded.");

    err_keep_a: assert property (
        OP_REQ && !op_ok |=> ref_value == $past(ref_value) && period == $past(period)
                             && dir_up == $past(dir_up))
        else $error("Parameter changed on error.");

    err_answer_a: assert property (
        OP_REQ && !op_ok |=> !ENABLE_OUT_FLAG && STATUS != cpupd_pkg::ST_OK && OP_DONE)
        else $error("Error not reported.");

    bad_id_a: assert property (
        OP_REQ && COUNTER_HANDLE != COUNTER_ID |=> STATUS == cpupd_pkg::ST_BAD_ID)
        else $error("Unknown identifier not reported.");

    busy_zero_a: assert property (
        OP_REQ |-> ##1 !BUSY [*2])
        else $error("Busy not zero.");

    eq_event_a: assert property (
        !CFG_FREQ_MODE && core_count == ref_value && !eq_prev |=> EQ_EVENT)
        else $error("Equal event missing.");

    reset_event_a: assert property (
        $rose(pin_sync[2]) && CFG_RESET_USE |=> RST_EVENT)
        else $error("Reset event missing.");

    dir_event_a: assert property (
        eff_up != eff_prev |=> DIR_EVENT)
        else $error("Direction event missing.");

    eq_once_a: assert property (
        eq_prev |=> !EQ_EVENT)
        else $error("Equal event repeated while equal.");

    ok_answer_a: assert property (
        op_ok |=> ENABLE_OUT_FLAG && STATUS == cpupd_pkg::ST_OK && OP_DONE)
        else $error("Good operation not answered.");

    period_load_a: assert property (
        per_load && OP.new_period == cpupd_pkg::PER_SHORT_VAL |=> period == cpupd_pkg::PSEL_SHORT)
        else $error("Interval not loaded.");

    combined_c: cover property (op_ok && OP.dir_req && OP.count_load_request
                                && OP.reference_load_request && OP.period_req);
    error_c:    cover property (OP_REQ && op_status == cpupd_pkg::ST_BAD_PER);
    eq_c:       cover property (EQ_EVENT);
    load_step_c: cover property (count_load && step);
    freq_c:     cover property (CFG_FREQ_MODE && per_load);

endmodule : cpupd_top

/* verif/test_cpupd_top.sv */
`timescale 1ns/1ps
// ============================================================
// Compares one value with its expectation and counts the result.
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end

module test_cpupd_top;
    logic                 CLK, RST_N, OP_REQ, CFG_ENABLE, CFG_INTERNAL_DIR, CFG_FREQ_MODE;
    logic                 CFG_RESET_USE, ACCESS_BUSY, PIN_COUNT, PIN_DIR, PIN_RESET;
    cpupd_pkg::cpupd_op_t OP;
    logic [7:0]           COUNTER_HANDLE;
    logic                 OP_DONE, ENABLE_OUT_FLAG, BUSY, EQ_EVENT, RST_EVENT, DIR_EVENT, DIR_UP_NOW;
    logic [15:0]          STATUS;
    logic [31:0]          COUNT_VALUE;
    int                   fail_count = 0;
    int                   n_compared = 0;
    int                   cycles = 0;
    int                   eq_cnt = 0;
    int                   dir_cnt = 0;
    int                   rst_cnt = 0;
    int                   e0, d0, r0;
    logic [15:0]          est [5] = '{16'h80a1, 16'h80d0, 16'h80c0, 16'h80b1, 16'h80b4};
    logic [15:0]          per [3] = '{16'h000a, 16'h0064, 16'h03e8};
    logic [31:0]          fhz [3] = '{32'h1f4, 32'h64, 32'h14};

    // Short interval counts keep the run brief.
    cpupd_top #(.CNT_W(32), .COUNTER_ID(8'h01), .SHORT_CYC(20), .MID_CYC(40), .LONG_CYC(80)) uut (
        .CLK(CLK), .RST_N(RST_N), .OP_REQ(OP_REQ), .OP(OP), .COUNTER_HANDLE(COUNTER_HANDLE),
        .CFG_ENABLE(CFG_ENABLE), .CFG_INTERNAL_DIR(CFG_INTERNAL_DIR), .CFG_FREQ_MODE(CFG_FREQ_MODE),
        .CFG_RESET_USE(CFG_RESET_USE), .ACCESS_BUSY(ACCESS_BUSY), .PIN_COUNT(PIN_COUNT),
        .PIN_DIR(PIN_DIR), .PIN_RESET(PIN_RESET), .OP_DONE(OP_DONE), .ENABLE_OUT_FLAG(ENABLE_OUT_FLAG),
        .BUSY(BUSY), .STATUS(STATUS), .COUNT_VALUE(COUNT_VALUE), .EQ_EVENT(EQ_EVENT),
        .RST_EVENT(RST_EVENT), .DIR_EVENT(DIR_EVENT), .DIR_UP_NOW(DIR_UP_NOW));

    // ============================================================
    // Clock of 50 ns period.
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // Counts event pulses and cuts a hang short.
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (EQ_EVENT === 1'b1) eq_cnt <= eq_cnt + 1;
        if (DIR_EVENT === 1'b1) dir_cnt <= dir_cnt + 1;
        if (RST_EVENT === 1'b1) rst_cnt <= rst_cnt + 1;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ============================================================
    // Prints the verdict and ends the run.
    task wrap_up;
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // One control operation, then its answer one cycle later.
    task automatic op(input logic [3:0] req, input logic [15:0] nd, input logic [31:0] nc,
                      input logic [31:0] nr, input logic [15:0] np, input logic [7:0] h,
                      input logic [15:0] st);
        @(posedge CLK);
        OP_REQ <= 1'b1;
        OP <= '{req[3], req[2], req[1], req[0], nd, nc, nr, np};
        COUNTER_HANDLE <= h;
        @(posedge CLK);
        OP_REQ <= 1'b0;
        OP <= '{1'b0, 1'b0, 1'b0, 1'b0, 16'h5a5a, 32'ha5a5a5a5, 32'h5a5a5a5a, 16'ha5a5};
        #1;
        `CHK(OP_DONE, 1'b1)
        `CHK(STATUS, st)
        `CHK(ENABLE_OUT_FLAG, st === 16'h0000)
        `CHK(BUSY, 1'b0)
        @(posedge CLK);
        #1;
    endtask : op

    // Count pin pulses three cycles wide, then time for them to settle.
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge CLK);
            PIN_COUNT <= 1'b1;
            repeat (3) @(posedge CLK);
            PIN_COUNT <= 1'b0;
            repeat (3) @(posedge CLK);
        end
        repeat (6) @(posedge CLK);
        #1;
    endtask : edges

    // ============================================================
    // Main sequence of operations and pin activity.
    initial begin
        RST_N = 1'b0;
        OP_REQ = 1'b0;
        OP = '0;
        COUNTER_HANDLE = 8'h01;
        CFG_ENABLE = 1'b1;
        CFG_INTERNAL_DIR = 1'b0;
        CFG_FREQ_MODE = 1'b0;
        CFG_RESET_USE = 1'b0;
        ACCESS_BUSY = 1'b0;
        PIN_COUNT = 1'b0;
        PIN_DIR = 1'b1;
        PIN_RESET = 1'b0;
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        #1;
        `CHK(STATUS, 16'h0000)
        `CHK(DIR_UP_NOW, 1'b1)
        `CHK(COUNT_VALUE, 32'h0)
        // Count load, then a reference load whose count value must be ignored.
        op(4'b0100, 16'h0, 32'h10, 32'h0, 16'h0, 8'h01, 16'h0000);
        `CHK(COUNT_VALUE, 32'h10)
        `CHK(dir_cnt, 0)
        op(4'b0010, 16'h0, 32'h55, 32'h14, 16'h0, 8'h01, 16'h0000);
        `CHK(COUNT_VALUE, 32'h10)
        e0 = eq_cnt;
        edges(4);
        `CHK(COUNT_VALUE, 32'h14)
        `CHK(eq_cnt, e0 + 1)
        // Each error code but ST_BAD_COUNT and ST_BAD_REF once; none of the requested loads may land.
        for (int i = 0; i < 5; i++) begin
            @(posedge CLK);
            CFG_ENABLE <= (i != 1);
            ACCESS_BUSY <= (i == 2);
            op({i == 3, 1'b1, 1'b0, i == 4}, 16'h0002, 32'h99, 32'h0, 16'h0005,
               (i == 0) ? 8'h02 : 8'h01, est[i]);
            `CHK(COUNT_VALUE, 32'h14)
        end
        CFG_ENABLE <= 1'b1;
        ACCESS_BUSY <= 1'b0;
        // Heading request with pin-controlled direction changes nothing.
        op(4'b1000, 16'hffff, 32'h0, 32'h0, 16'h0, 8'h01, 16'h0000);
        repeat (3) @(posedge CLK);
        #1;
        `CHK(DIR_UP_NOW, 1'b1)
        // Heading, count and reference in one operation, then count down.
        @(posedge CLK);
        CFG_INTERNAL_DIR <= 1'b1;
        repeat (3) @(posedge CLK);
        d0 = dir_cnt;
        op(4'b1110, 16'hffff, 32'h30, 32'h2e, 16'h0, 8'h01, 16'h0000);
        `CHK(COUNT_VALUE, 32'h30)
        e0 = eq_cnt;
        edges(2);
        `CHK(COUNT_VALUE, 32'h2e)
        `CHK(DIR_UP_NOW, 1'b0)
        `CHK(dir_cnt, d0 + 1)
        `CHK(eq_cnt, e0 + 1)
        // Every legal interval setting is accepted.
        for (int i = 0; i < 3; i++) begin
            op(4'b0001, 16'h0, 32'h0, 32'h0, per[i], 8'h01, 16'h0000);
            `CHK(COUNT_VALUE, 32'h2e)
        end
        // Frequency mode: a pin rising every 4 cycles gives 5, 10 and 20 edges per
        // interval, which scale to hertz by 100, 10 and 1.
        @(posedge CLK);
        CFG_FREQ_MODE <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            op(4'b0001, 16'h0, 32'h0, 32'h0, per[i], 8'h01, 16'h0000);
            repeat (90) begin
                repeat (2) @(posedge CLK);
                PIN_COUNT <= ~PIN_COUNT;
            end
            #1;
            `CHK(COUNT_VALUE, fhz[i])
        end
        @(posedge CLK);
        CFG_FREQ_MODE <= 1'b0;
        // External reset clears the count and raises its event.
        @(posedge CLK);
        CFG_RESET_USE <= 1'b1;
        r0 = rst_cnt;
        @(posedge CLK);
        PIN_RESET <= 1'b1;
        repeat (4) @(posedge CLK);
        PIN_RESET <= 1'b0;
        repeat (6) @(posedge CLK);
        #1;
        `CHK(COUNT_VALUE, 32'h0)
        `CHK(rst_cnt, r0 + 1)
        wrap_up();
    end
endmodule : test_cpupd_top
